// ---- dac_main_config_map.vh ----
/*
  Offsets, field positions, reset value and field codes of the main
  datapath configuration register.
  Assumes it is included once per compile unit by its bare name.
*/
// Behaviour
// - Register resets to 0x049c and sits at address 0x00.
// - Bit 15 set applies offset correction on pair one, else bypassed.
// - Bit 14 set applies offset correction on pair two, else bypassed.
// - Bit 13 set enables phase and gain correction on pair one.
// - Bit 12 set enables phase and gain correction on pair two.
// - Bits 11:8 select interpolation 1x,2x,4x,8x,16x; default 8x.
// - Bit 7 enables the input elastic buffer; resets to one.
// - Bit 4 set drives the alarm pin; cleared puts it high impedance.
// - Alarm polarity 0 is active low, 1 active high; default high.
// - Bit 2 set resynchronizes elastic buffer output pointer from sync source.
// - After a taken sync, all divided clocks are phase aligned.
// - Bit 1 set inserts inverse sinc filter into pair one path.
// - Bit 0 set inserts inverse sinc filter into pair two path.
// - Bits 6 and 5 are reserved, no function, reset to zero.
`ifndef DAC_MAIN_CONFIG_MAP_VH
`define DAC_MAIN_CONFIG_MAP_VH

`define MAIN_CFG_ADDR 7'h00
`define MAIN_CFG_RESET 16'h049c

`define BIT_PAIR1_QUAD_OFFSET 15
`define BIT_PAIR2_QUAD_OFFSET 14
`define BIT_PAIR1_PHASE_GAIN 13
`define BIT_PAIR2_PHASE_GAIN 12
`define FLD_INTERP_HI 11
`define FLD_INTERP_LO 8
`define BIT_ELASTIC_BUF 7
`define BIT_RSVD_HI 6
`define BIT_RSVD_LO 5
`define BIT_ALARM_OUT_ENA 4
`define BIT_ALARM_POL 3
`define BIT_CLKDIV_SYNC 2
`define BIT_PAIR1_SINC_COMP 1
`define BIT_PAIR2_SINC_COMP 0

`define INTERP_1X 4'h0
`define INTERP_2X 4'h1
`define INTERP_4X 4'h2
`define INTERP_8X 4'h4
`define INTERP_16X 4'h8

`endif

// ---- main_datapath_config.v ----
/*
  Main datapath configuration register of the converter and the small
  pieces of control logic that it steers directly: alarm pin drive,
  output pointer resync and the divided clock enables.
  Assumes the serial configuration engine delivers one-cycle write and
  read strobes on clk, internal alarm and datapath logic run on clk,
  and the sync source arrives asynchronously from a pin.
*/
`timescale 1ns/10ps
`include "dac_main_config_map.vh"

module main_datapath_config #(
  parameter ADDR_W = 7
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Serial configuration register port
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [ADDR_W-1:0] cfg_addr,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata,
  output reg cfg_rvalid,
  // Alarm source and pin
  input wire alarm_event,
  output reg alarm_o,
  output reg alarm_oe,
  // Sync source chosen by the sync selection register
  input wire sync_source,
  // Datapath controls
  output reg pair1_quad_offset_enable,
  output reg pair2_quad_offset_enable,
  output reg pair1_phase_gain_enable,
  output reg pair2_phase_gain_enable,
  output reg pair1_sinc_comp_enable,
  output reg pair2_sinc_comp_enable,
  output reg elastic_buf_enable,
  output reg [4:0] interp_ratio,
  output reg interp_code_bad,
  // Elastic buffer pointer and divided clocks
  output reg out_ptr_sync,
  output reg div2_en,
  output reg div4_en,
  output reg div8_en,
  output reg div16_en,
  output reg sample_en
);

  // Interpolation code to ratio; unlisted codes fall back to 1x.
  function [4:0] interp_decode;
    input [3:0] code;
    begin
      case (code)
        `INTERP_1X: interp_decode = 5'h01;
        `INTERP_2X: interp_decode = 5'h02;
        `INTERP_4X: interp_decode = 5'h04;
        `INTERP_8X: interp_decode = 5'h08;
        `INTERP_16X: interp_decode = 5'h10;
        default: interp_decode = 5'h01;
      endcase
    end
  endfunction

  // A code outside the listed set is flagged, so software can tell that the
  // datapath has quietly fallen back to 1x.
  function code_valid;
    input [3:0] code;
    begin
      case (code)
        `INTERP_1X, `INTERP_2X, `INTERP_4X, `INTERP_8X, `INTERP_16X: code_valid = 1'b1;
        default: code_valid = 1'b0;
      endcase
    end
  endfunction

  reg [15:0] cfg_reg;
  reg [15:0] cfg_next;
  reg sync_meta_reg;
  reg sync_sample_reg;
  reg sync_last_reg;
  reg [3:0] div_cnt_reg;
  reg [3:0] div_cnt_next;
  reg [3:0] sample_mask;
  wire addr_hit;
  wire sync_rise;
  wire [3:0] interp_code;

  // Only this one address is decoded; writes elsewhere are dropped.
  assign addr_hit = (cfg_addr == `MAIN_CFG_ADDR);
  assign interp_code = cfg_reg[`FLD_INTERP_HI:`FLD_INTERP_LO];
  // The edge detector reads only the second and third stages.
  assign sync_rise = sync_sample_reg & ~sync_last_reg;

  // Reserved bits are stored as written so a read-back matches the
  // write; they steer nothing.
  always @* begin
    cfg_next = cfg_reg;
    if (cfg_wr && addr_hit) begin
      cfg_next = cfg_wdata;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      cfg_reg <= `MAIN_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Read answer one cycle after the strobe; other addresses read zero.
  always @(posedge clk) begin
    if (!nrst) begin
      cfg_rdata <= 16'h0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= addr_hit ? cfg_reg : 16'h0000;
      end
    end
  end

  // Datapath enables follow the register one cycle after it changes.
  // The lag keeps every control a plain flip-flop output with no decode behind it.
  always @(posedge clk) begin
    if (!nrst) begin
      pair1_quad_offset_enable <= 1'b0;
      pair2_quad_offset_enable <= 1'b0;
      pair1_phase_gain_enable <= 1'b0;
      pair2_phase_gain_enable <= 1'b0;
      pair1_sinc_comp_enable <= 1'b0;
      pair2_sinc_comp_enable <= 1'b0;
      elastic_buf_enable <= 1'b0;
      interp_ratio <= 5'h01;
      interp_code_bad <= 1'b0;
    end else begin
      pair1_quad_offset_enable <= cfg_reg[`BIT_PAIR1_QUAD_OFFSET];
      pair2_quad_offset_enable <= cfg_reg[`BIT_PAIR2_QUAD_OFFSET];
      pair1_phase_gain_enable <= cfg_reg[`BIT_PAIR1_PHASE_GAIN];
      pair2_phase_gain_enable <= cfg_reg[`BIT_PAIR2_PHASE_GAIN];
      pair1_sinc_comp_enable <= cfg_reg[`BIT_PAIR1_SINC_COMP];
      pair2_sinc_comp_enable <= cfg_reg[`BIT_PAIR2_SINC_COMP];
      elastic_buf_enable <= cfg_reg[`BIT_ELASTIC_BUF];
      interp_ratio <= interp_decode(interp_code);
      interp_code_bad <= ~code_valid(interp_code);
    end
  end

  // Alarm pin: the polarity bit picks the asserted level, the enable
  // bit decides whether the pin is driven at all.
  always @(posedge clk) begin
    if (!nrst) begin
      alarm_o <= 1'b0;
      alarm_oe <= 1'b0;
    end else begin
      alarm_o <= cfg_reg[`BIT_ALARM_POL] ? alarm_event : ~alarm_event;
      alarm_oe <= cfg_reg[`BIT_ALARM_OUT_ENA];
    end
  end

  // Two-stage synchroniser for the asynchronous sync source.
  always @(posedge clk) begin
    if (!nrst) begin
      sync_meta_reg <= 1'b0;
      sync_sample_reg <= 1'b0;
      sync_last_reg <= 1'b0;
    end else begin
      sync_meta_reg <= sync_source;
      sync_sample_reg <= sync_meta_reg;
      sync_last_reg <= sync_sample_reg;
    end
  end

  // One counter feeds every divided enable, so clearing it on a taken
  // sync puts all of them back in phase at once.
  always @* begin
    div_cnt_next = div_cnt_reg + 4'h1;
    if (sync_rise && cfg_reg[`BIT_CLKDIV_SYNC]) begin
      div_cnt_next = 4'h0;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  // The sample enable masks the shared counter, so its phase is tied to the
  // other divided enables and a taken sync realigns it with them.
  // At 1x the mask is empty and the enable stays high every cycle.
  always @* begin
    sample_mask = interp_ratio[4:1] == 4'h0 ? 4'h0 : (interp_ratio[3:0] - 4'h1);
    if (interp_ratio[4]) begin
      sample_mask = 4'hf;
    end
  end

  // The enables decode the next counter value, so they rise on the same
  // edge as the pointer sync pulse while staying registered outputs.
  // A sync edge seen with the enable bit clear is dropped on purpose.
  always @(posedge clk) begin
    if (!nrst) begin
      out_ptr_sync <= 1'b0;
      div2_en <= 1'b0;
      div4_en <= 1'b0;
      div8_en <= 1'b0;
      div16_en <= 1'b0;
      sample_en <= 1'b0;
    end else begin
      out_ptr_sync <= sync_rise & cfg_reg[`BIT_CLKDIV_SYNC];
      div2_en <= div_cnt_next[0] == 1'b0;
      div4_en <= div_cnt_next[1:0] == 2'h0;
      div8_en <= div_cnt_next[2:0] == 3'h0;
      div16_en <= div_cnt_next == 4'h0;
      sample_en <= (div_cnt_next & sample_mask) == 4'h0;
    end
  end

endmodule // main_datapath_config

// ---- dac_cfg_properties.sv ----
/* Assertions on the ports of the main datapath configuration register.
   Assumes a single clock domain and a bind into main_datapath_config. */
`timescale 1ns/10ps
module dac_cfg_props #(
  parameter ADDR_W = 7
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [ADDR_W-1:0] cfg_addr,
  input wire [15:0] cfg_wdata,
  input wire [15:0] cfg_rdata,
  input wire cfg_rvalid,
  // Alarm and sync
  input wire alarm_event,
  input wire alarm_o,
  input wire alarm_oe,
  input wire sync_source,
  input wire out_ptr_sync,
  // Datapath controls
  input wire pair1_quad_offset_enable,
  input wire pair2_quad_offset_enable,
  input wire pair1_phase_gain_enable,
  input wire pair2_phase_gain_enable,
  input wire pair1_sinc_comp_enable,
  input wire pair2_sinc_comp_enable,
  input wire elastic_buf_enable,
  input wire [4:0] interp_ratio,
  // Divided enables
  input wire div2_en,
  input wire div4_en,
  input wire div8_en,
  input wire div16_en,
  input wire sample_en
);
  wire wa = cfg_wr && (cfg_addr == 0);
  reg sync_ena_reg;
  // Mirrors the sync enable so that ignored edges are not expected to fire.
  always @(posedge clk) begin
    if (!nrst) sync_ena_reg <= 1'b1;
    else if (wa) sync_ena_reg <= cfg_wdata[2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_valid: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe not answered");
  a_write_readback: assert property (wa ##1 (!cfg_wr)[*2] ##1
    (cfg_rd && cfg_addr == 0 && !cfg_wr) |=> cfg_rdata == $past(cfg_wdata, 4))
    else $error("read back differs from write");
  a_offset_follow: assert property (wa |=> ##1
    {pair1_quad_offset_enable, pair2_quad_offset_enable} == $past(cfg_wdata[15:14], 2))
    else $error("offset enables do not follow the write");
  a_gain_follow: assert property (wa |=> ##1
    {pair1_phase_gain_enable, pair2_phase_gain_enable} == $past(cfg_wdata[13:12], 2))
    else $error("gain enables do not follow the write");
  a_sinc_follow: assert property (wa |=> ##1
    {pair1_sinc_comp_enable, pair2_sinc_comp_enable} == $past(cfg_wdata[1:0], 2))
    else $error("sinc enables do not follow the write");
  a_buf_follow: assert property (wa |=> ##1
    elastic_buf_enable == $past(cfg_wdata[7], 2))
    else $error("buffer enable does not follow the write");
  a_alarm_drive: assert property (wa |=> ##1
    alarm_oe == $past(cfg_wdata[4], 2))
    else $error("alarm drive does not follow the write");
  a_alarm_pol: assert property (wa |=> ##1
    alarm_o == ($past(alarm_event) ~^ $past(cfg_wdata[3], 2)))
    else $error("alarm level has the wrong polarity");
  a_interp_eight: assert property (wa && cfg_wdata[11:8] == 4'h4 |=> ##1
    interp_ratio == 5'h08)
    else $error("interpolation ratio is not eight");
  a_sync_taken: assert property ($rose(sync_source) && sync_ena_reg |->
    ##[1:6] out_ptr_sync)
    else $error("enabled sync edge was not taken");
  a_sync_ignored: assert property (out_ptr_sync |-> $past(sync_ena_reg))
    else $error("sync taken while disabled");
  a_div_align: assert property (out_ptr_sync |->
    div2_en && div4_en && div8_en && div16_en && sample_en)
    else $error("divided enables not aligned");
endmodule // dac_cfg_props
bind main_datapath_config dac_cfg_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ---- tb.sv ----
/* Self-checking bench for the main datapath configuration register.
   Assumes one-cycle strobes and an answer one clock after each strobe. */
`timescale 1ns/10ps
module tb;
  reg clk = 0, nrst = 0, wr = 0, rd = 0, ev = 0, sy = 0;
  reg [6:0] ad = 0;
  reg [15:0] wd = 0;
  wire [15:0] rdat;
  wire [4:0] ir;
  wire rv, ao, oe, o1, o2, g1, g2, s1, s2, eb, bad, ps, d2, d4, d8, d16, se;
  integer error_cnt = 0, n_tests = 0, i;
  main_datapath_config dut (.clk(clk), .nrst(nrst), .cfg_wr(wr), .cfg_rd(rd),
    .cfg_addr(ad), .cfg_wdata(wd), .cfg_rdata(rdat), .cfg_rvalid(rv), .alarm_event(ev),
    .alarm_o(ao), .alarm_oe(oe), .sync_source(sy), .pair1_quad_offset_enable(o1),
    .pair2_quad_offset_enable(o2), .pair1_phase_gain_enable(g1),
    .pair2_phase_gain_enable(g2), .pair1_sinc_comp_enable(s1),
    .pair2_sinc_comp_enable(s2), .elastic_buf_enable(eb), .interp_ratio(ir),
    .interp_code_bad(bad), .out_ptr_sync(ps), .div2_en(d2), .div4_en(d4),
    .div8_en(d8), .div16_en(d16), .sample_en(se));
  initial forever #5 clk = ~clk;
  task ck(input string n, input [15:0] e, input [15:0] s);
    n_tests++;
    if (e !== s) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wra(input [6:0] a, input [15:0] d);
    @(negedge clk) {wr, ad, wd} = {1'b1, a, d};
    @(negedge clk) wr = 0;
    @(negedge clk);
  endtask
  task rda(input [6:0] a, input [15:0] e);
    @(negedge clk) {rd, ad} = {1'b1, a};
    @(negedge clk) rd = 0;
    ck("rdata", e, rdat);
    ck("rvalid", 1, rv);
  endtask
  task t_fields;
    reg [15:0] d;
    for (i = 0; i < 5; i++) begin
      d = {i[0] ? 4'ha : 4'h5, i == 0 ? 4'h0 : 4'h1 << (i - 1), i[0] ? 8'h83 : 8'h12};
      wra(0, d);
      ck("ctl", {d[15:12], d[7], d[4], d[1:0]}, {o1, o2, g1, g2, eb, oe, s1, s2});
      ck("ratio", 5'h01 << i, ir);
      rda(0, d);
    end
    wra(0, 16'h0300);
    ck("bad code", 1, bad);
    ck("bad ratio", 5'h01, ir);
    $display("t_fields done");
  endtask
  task t_reset;
    rda(0, 16'h049c);
    ck("reset ctl", 7'h68, {eb, oe, ir});
    ck("reset off", 0, {o1, o2, g1, g2, s1, s2});
    ck("reset alarm", 0, ao);
    $display("t_reset done");
  endtask
  task t_reserved;
    wra(0, 16'h0004);
    wra(7'h01, 16'hffff);
    rda(0, 16'h0004);
    rda(7'h01, 16'h0000);
    $display("t_reserved done");
  endtask
  task t_alarm;
    ev = 1;
    wra(0, 16'h0010);
    ck("alarm low", 0, ao);
    wra(0, 16'h0008);
    ck("alarm high", 2'b01, {oe, ao});
    ev = 0;
    $display("t_alarm done");
  endtask
  task t_sync(input en);
    reg hit;
    hit = 0;
    wra(0, {13'h0, en, 2'h0});
    @(negedge clk) sy = 1;
    repeat (8) @(negedge clk) if (ps) begin
      hit = 1;
      ck("divs", 5'h1f, {d2, d4, d8, d16, se});
    end
    ck("ptr sync", en, hit);
    sy = 0;
    repeat (3) @(negedge clk);
    $display("t_sync done");
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    t_reset;
    t_fields;
    t_reserved;
    t_alarm;
    t_sync(1);
    t_sync(0);
    test_done;
  end
endmodule // tb
